// ===== rtl/bfsup_defines.svh
// Timing counts and code values for the buck fault supervisor
`ifndef BFSUP_DEFINES_SVH
`define BFSUP_DEFINES_SVH

// ----------------------------------------------------------------
// Clock and times
// ----------------------------------------------------------------
`define BFSUP_CLK_MHZ        250
`define BFSUP_START_DLY_US   20
`define BFSUP_OC_DLY_US      10
`define BFSUP_VF_DLY_US      2
// Least times round up: whole microseconds give exact counts
`define BFSUP_START_CYC      (`BFSUP_START_DLY_US * `BFSUP_CLK_MHZ)
`define BFSUP_OC_CYC         (`BFSUP_OC_DLY_US * `BFSUP_CLK_MHZ)
`define BFSUP_VF_CYC         (`BFSUP_VF_DLY_US * `BFSUP_CLK_MHZ)
`define BFSUP_CNT_W          13

// ----------------------------------------------------------------
// Power-good pull-down codes
// ----------------------------------------------------------------
`define BFSUP_PG_RELEASE     2'h0
`define BFSUP_PG_95_OHM      2'h1
`define BFSUP_PG_65_OHM      2'h2
`define BFSUP_PG_35_OHM      2'h3

`endif

// ===== rtl/bfsup_pkg.sv
// Types shared by the buck fault supervisor files
package bfsup_pkg;

  // Comparator results from the analog front end
  typedef struct packed {
    logic oc_above;      // Current sense above output sense
    logic fb_above_ovr;  // Feedback above ov_rising_threshold
    logic fb_below_ovf;  // Feedback below ov_falling_threshold
    logic fb_below_uv;   // Feedback below uv_threshold
    logic ot_hot;        // Over overtemp_rising_threshold, until hysteresis
    logic ss_taper;      // Soft-start current has tapered off
  } bfsup_cmp_t;

  // Fault status: latched faults and non-latching over-temperature state
  typedef struct packed {
    logic overcurrent_fault;
    logic overvoltage_fault;
    logic undervoltage_fault;
    logic overtemp_state;
  } bfsup_flt_t;

  // Sequencer states
  typedef enum logic [1:0] {
    BFSUP_OFF,
    BFSUP_DELAY,
    BFSUP_RAMP,
    BFSUP_RUN
  } bfsup_st_t;

endpackage

// ===== rtl/bfsup_debounce.sv
// Debounce filter: output high after input held high beyond a count
`timescale 1ns/1ps
module bfsup_debounce #(
  parameter int CNT_W = 13,
  parameter int COUNT = 500
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Condition and filtered result
  input  wire logic cond,
  output logic      hit
);

  logic [CNT_W-1:0] cnt_ff;
  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(COUNT);

  // -----------------------------------------------------------
  // Counter restarts when the condition drops
  // -----------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff <= '0;
    end else if (!cond) begin
      cnt_ff <= '0;
    end else if (cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Registered hit, one cycle past the full count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hit <= 1'b0;
    end else begin
      hit <= cond && (cnt_ff == LIMIT);
    end
  end

endmodule // bfsup_debounce

// ===== rtl/bfsup_supervisor.sv
// Buck fault supervisor: start sequence, power-good code, fault latches
`timescale 1ns/1ps
`include "bfsup_defines.svh"

module bfsup_supervisor #(
  parameter int START_CYC = `BFSUP_START_CYC,
  parameter int OC_CYC    = `BFSUP_OC_CYC,
  parameter int VF_CYC    = `BFSUP_VF_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_b,
  // Supply and enable levels
  input  wire logic              por_ok,
  input  wire logic              enable_in,
  // Analog comparator results
  input  wire bfsup_pkg::bfsup_cmp_t cmp_in,
  // PWM requests from the modulator
  input  wire logic              pwm_high_req,
  input  wire logic              pwm_low_req,
  // Reference control
  output logic                   setpoint_ref_clamp,
  output logic                   ref_amp_enable,
  output logic                   ramp_start,
  // Gate permissions
  output logic                   high_side_gate,
  output logic                   low_side_gate,
  // Status
  output logic [1:0]             power_good_out,
  output logic                   soft_start_done_flag,
  output logic                   diode_emulation_mode,
  output bfsup_pkg::bfsup_flt_t  fault_status
);
  import bfsup_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  bfsup_cmp_t       cmp_meta_ff;
  bfsup_cmp_t       cmp_sync_ff;
  logic             active;
  logic             en_clear;
  logic             oc_hit;
  logic             ovr_hit;
  logic             ovf_hit;
  logic             uv_hit;
  logic             dly_hit;
  bfsup_st_t        st_ff;
  bfsup_st_t        nxt_st;
  logic             oc_ff;
  logic             ov_ff;
  logic             uv_ff;
  logic             ot_ff;
  logic             ov_low_side_gate_ff;
  logic             latched_off;
  logic             ramping;

  // Shared decode: a fault code for a fault set
  function automatic logic [1:0] pg_code(input logic oc, input logic ov,
                                         input logic uv, input logic run);
    if (oc) begin
      pg_code = `BFSUP_PG_35_OHM;
    end else if (ov) begin
      pg_code = `BFSUP_PG_65_OHM;
    end else if (uv || !run) begin
      pg_code = `BFSUP_PG_95_OHM;
    end else begin
      pg_code = `BFSUP_PG_RELEASE;
    end
  endfunction

  // ----------------------------------------------------------------
  // Comparator synchroniser
  // ----------------------------------------------------------------
  // Two flops; only the second stage is used downstream
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cmp_meta_ff <= '0;
      cmp_sync_ff <= '0;
    end else begin
      cmp_meta_ff <= cmp_in;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  assign active   = por_ok && enable_in;
  assign en_clear = !por_ok || !enable_in;

  // ----------------------------------------------------------------
  // Debounce filters
  // ----------------------------------------------------------------
  bfsup_debounce #(.CNT_W(`BFSUP_CNT_W), .COUNT(START_CYC)) u_dly (
    .clk   (clk),
    .rst_b (rst_b),
    .cond  (active && st_ff == BFSUP_DELAY),
    .hit   (dly_hit)
  );
  bfsup_debounce #(.CNT_W(`BFSUP_CNT_W), .COUNT(OC_CYC)) u_oc (
    .clk   (clk),
    .rst_b (rst_b),
    .cond  (cmp_sync_ff.oc_above),
    .hit   (oc_hit)
  );
  bfsup_debounce #(.CNT_W(`BFSUP_CNT_W), .COUNT(VF_CYC)) u_ovr (
    .clk   (clk),
    .rst_b (rst_b),
    .cond  (cmp_sync_ff.fb_above_ovr),
    .hit   (ovr_hit)
  );
  bfsup_debounce #(.CNT_W(`BFSUP_CNT_W), .COUNT(VF_CYC)) u_ovf (
    .clk   (clk),
    .rst_b (rst_b),
    .cond  (cmp_sync_ff.fb_below_ovf),
    .hit   (ovf_hit)
  );
  bfsup_debounce #(.CNT_W(`BFSUP_CNT_W), .COUNT(VF_CYC)) u_uv (
    .clk   (clk),
    .rst_b (rst_b),
    .cond  (cmp_sync_ff.fb_below_uv),
    .hit   (uv_hit)
  );

  // ----------------------------------------------------------------
  // Start sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      BFSUP_OFF: begin
        if (active) begin
          nxt_st = BFSUP_DELAY;
        end
      end
      BFSUP_DELAY: begin
        if (dly_hit) begin
          nxt_st = BFSUP_RAMP;
        end
      end
      BFSUP_RAMP: begin
        if (cmp_sync_ff.ss_taper) begin
          nxt_st = BFSUP_RUN;
        end
      end
      BFSUP_RUN: begin
        nxt_st = BFSUP_RUN;
      end
      default: begin
        nxt_st = BFSUP_OFF;
      end
    endcase
    if (!active) begin
      nxt_st = BFSUP_OFF;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= BFSUP_OFF;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Reference control outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      setpoint_ref_clamp <= 1'b1;
      ref_amp_enable     <= 1'b0;
      ramp_start         <= 1'b0;
    end else begin
      setpoint_ref_clamp <= (nxt_st == BFSUP_OFF);
      ref_amp_enable     <= (nxt_st != BFSUP_OFF);
      ramp_start         <= (nxt_st == BFSUP_RAMP) || (nxt_st == BFSUP_RUN);
    end
  end

  // ----------------------------------------------------------------
  // Fault latches, non-latching over-temperature state, OV low-side toggle
  // ----------------------------------------------------------------
  // Overcurrent: set wins over clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      oc_ff <= 1'b0;
    end else if (oc_hit && por_ok) begin
      oc_ff <= 1'b1;
    end else if (en_clear) begin
      oc_ff <= 1'b0;
    end
  end

  // Overvoltage: only supply reset clears
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ov_ff <= 1'b0;
    end else if (ovr_hit && por_ok) begin
      ov_ff <= 1'b1;
    end else if (!por_ok) begin
      ov_ff <= 1'b0;
    end
  end

  // Undervoltage: only while converter is enabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      uv_ff <= 1'b0;
    end else if (uv_hit && active && st_ff == BFSUP_RUN) begin
      uv_ff <= 1'b1;
    end else if (en_clear) begin
      uv_ff <= 1'b0;
    end
  end

  // Over-temperature: non-latching, follows comparator hysteresis
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ot_ff <= 1'b0;
    end else if (en_clear) begin
      ot_ff <= 1'b0;
    end else begin
      ot_ff <= cmp_sync_ff.ot_hot;
    end
  end

  // Low-side discharge toggle while OV latched
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ov_low_side_gate_ff <= 1'b0;
    end else if (!ov_ff) begin
      ov_low_side_gate_ff <= 1'b0;
    end else if (ovr_hit) begin
      ov_low_side_gate_ff <= 1'b1;
    end else if (ovf_hit) begin
      ov_low_side_gate_ff <= 1'b0;
    end
  end

  assign latched_off = oc_ff || ov_ff || uv_ff;
  assign ramping     = (st_ff == BFSUP_RAMP) || (st_ff == BFSUP_RUN);

  // ----------------------------------------------------------------
  // Gate permissions
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
    end else if (ov_ff) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= ov_low_side_gate_ff;
    end else if (latched_off || ot_ff || !ramping || !active) begin
      high_side_gate <= 1'b0;
      low_side_gate  <= 1'b0;
    end else begin
      high_side_gate <= pwm_high_req && !pwm_low_req;
      low_side_gate  <= pwm_low_req && !pwm_high_req;
    end
  end

  // ----------------------------------------------------------------
  // Power-good code and status
  // ----------------------------------------------------------------
  // Over-temperature is not an input to the code
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      power_good_out       <= `BFSUP_PG_95_OHM;
      soft_start_done_flag <= 1'b0;
      diode_emulation_mode <= 1'b0;
    end else begin
      // Priority: overcurrent, overvoltage, then undervoltage or start
      power_good_out       <= pg_code(oc_ff, ov_ff, uv_ff,
                                      st_ff == BFSUP_RUN);
      soft_start_done_flag <= (st_ff == BFSUP_RUN);
      diode_emulation_mode <= (st_ff == BFSUP_RUN) && !latched_off;
    end
  end

  assign fault_status = '{overcurrent_fault:  oc_ff,
                          overvoltage_fault:  ov_ff,
                          undervoltage_fault: uv_ff,
                          overtemp_state:     ot_ff};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  oc_code_a: assert property (oc_ff |=> power_good_out == `BFSUP_PG_35_OHM)
    else $error("overcurrent code not 35 ohm");
  ov_code_a: assert property (ov_ff && !oc_ff |=> power_good_out == `BFSUP_PG_65_OHM)
    else $error("overvoltage code not 65 ohm");
  uv_code_a: assert property (uv_ff && !oc_ff && !ov_ff
                              |=> power_good_out == `BFSUP_PG_95_OHM)
    else $error("undervoltage code not 95 ohm");
  ss_code_a: assert property (st_ff == BFSUP_RAMP && !oc_ff && !ov_ff
                              |=> power_good_out == `BFSUP_PG_95_OHM)
    else $error("soft-start code not 95 ohm");
  ov_hold_a: assert property (ov_ff && por_ok |=> ov_ff)
    else $error("overvoltage latch cleared without POR");
  oc_set_a: assert property (oc_hit && por_ok |=> oc_ff)
    else $error("overcurrent not latched");
  uv_clr_a: assert property (uv_ff && !enable_in && !uv_hit |=> !uv_ff)
    else $error("undervoltage not cleared by enable low");
  ot_gate_a: assert property (ot_ff && !ov_ff |=> !high_side_gate && !low_side_gate)
    else $error("gates active in over-temperature");
  off_gate_a: assert property (latched_off |=> !high_side_gate)
    else $error("high side on while latched off");
  ov_lon_a: assert property (ov_ff && ov_low_side_gate_ff |=> low_side_gate)
    else $error("low side not discharging");
  done_flag_a: assert property (st_ff == BFSUP_RUN |=> soft_start_done_flag)
    else $error("done flag not set");
  clamp_a: assert property (active && st_ff == BFSUP_OFF |=> !setpoint_ref_clamp)
    else $error("clamp not released");
  uv_set_a: assert property (uv_hit && active && st_ff == BFSUP_RUN |=> uv_ff)
    else $error("undervoltage not latched");
  ov_loff_a: assert property (ov_ff && !ov_low_side_gate_ff |=> !low_side_gate)
    else $error("low side still on below falling threshold");

  start_c: cover property (st_ff == BFSUP_RAMP ##1 st_ff == BFSUP_RUN);
  oc_c: cover property ($rose(oc_ff));
  ov_tog_c: cover property ($rose(low_side_gate) && ov_ff);
  ot_c: cover property ($rose(ot_ff));
  uv_c: cover property ($rose(uv_ff));

endmodule // bfsup_supervisor

// ===== tb/test_buck_fault_supervisor.sv
// Self-checking testbench for the buck fault supervisor
`timescale 1ns/1ps
`include "bfsup_defines.svh"
module test_buck_fault_supervisor;
  import bfsup_pkg::*;
  // ----------------------------------------------------------------
  // Shortened counts and bench signals
  // ----------------------------------------------------------------
  localparam int ST = 20;
  localparam int OC = 10;
  localparam int VF = 4;
  logic       clk;
  logic       rst_b;
  logic       por_ok;
  logic       enable_in;
  bfsup_cmp_t cmp;
  logic       pwm_high_req;
  logic       pwm_low_req;
  logic       clamp;
  logic       ref_amp;
  logic       ramp;
  logic       hs_gate;
  logic       ls_gate;
  logic [1:0] pg;
  logic       ss_done;
  logic       diode_em;
  bfsup_flt_t flt;
  int         n_mismatch;
  int         samples_checked;

  // Device under test with short debounce counts
  bfsup_supervisor #(.START_CYC(ST), .OC_CYC(OC), .VF_CYC(VF)) u_dut (
    .clk                  (clk),
    .rst_b                (rst_b),
    .por_ok               (por_ok),
    .enable_in            (enable_in),
    .cmp_in               (cmp),
    .pwm_high_req         (pwm_high_req),
    .pwm_low_req          (pwm_low_req),
    .setpoint_ref_clamp   (clamp),
    .ref_amp_enable       (ref_amp),
    .ramp_start           (ramp),
    .high_side_gate       (hs_gate),
    .low_side_gate        (ls_gate),
    .power_good_out       (pg),
    .soft_start_done_flag (ss_done),
    .diode_emulation_mode (diode_em),
    .fault_status         (flt)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare one value, count and report
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Let n edges pass, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Supply dip clears every latch
  task automatic por_reset();
    @(posedge clk);
    por_ok    <= 1'b0;
    enable_in <= 1'b0;
    cmp       <= '0;
    cyc(3);
    @(posedge clk);
    por_ok <= 1'b1;
    cyc(2);
  endtask

  // Enable, walk the start sequence into run
  task automatic bring_up();
    @(posedge clk);
    enable_in <= 1'b1;
    cyc(3);
    check(clamp, 1'b0);
    check(ref_amp, 1'b1);
    check(pg, `BFSUP_PG_95_OHM);
    cyc(ST - 6);
    check(ramp, 1'b0);
    cyc(8);
    check(ramp, 1'b1);
    check(ss_done, 1'b0);
    @(posedge clk);
    cmp.ss_taper <= 1'b1;
    cyc(8);
    check(ss_done, 1'b1);
    check(pg, `BFSUP_PG_RELEASE);
    check(diode_em, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Enable while supply is low keeps the clamp on
  task automatic test_por_hold();
    @(posedge clk);
    por_ok    <= 1'b0;
    enable_in <= 1'b1;
    cyc(6);
    check(clamp, 1'b1);
    check(ref_amp, 1'b0);
    por_reset();
  endtask

  // Short dip filtered, long dip latches, enable low clears
  task automatic test_uv();
    bring_up();
    check(hs_gate, 1'b1);
    @(posedge clk);
    cmp.fb_below_uv <= 1'b1;
    cyc(VF - 1);
    @(posedge clk);
    cmp.fb_below_uv <= 1'b0;
    cyc(VF + 8);
    check(flt.undervoltage_fault, 1'b0);
    @(posedge clk);
    cmp.fb_below_uv <= 1'b1;
    cyc(VF + 8);
    check(flt.undervoltage_fault, 1'b1);
    check(pg, `BFSUP_PG_95_OHM);
    check({hs_gate, ls_gate}, 2'h0);
    @(posedge clk);
    cmp.fb_below_uv <= 1'b0;
    cyc(6);
    check(flt.undervoltage_fault, 1'b1);
    @(posedge clk);
    enable_in <= 1'b0;
    cyc(4);
    check(flt.undervoltage_fault, 1'b0);
    por_reset();
  endtask

  // Overcurrent debounce, strongest code, latch until enable low
  task automatic test_oc();
    bring_up();
    @(posedge clk);
    cmp.oc_above <= 1'b1;
    cyc(OC - 2);
    check(flt.overcurrent_fault, 1'b0);
    cyc(10);
    check(flt.overcurrent_fault, 1'b1);
    check(pg, `BFSUP_PG_35_OHM);
    check({hs_gate, ls_gate}, 2'h0);
    @(posedge clk);
    cmp.oc_above <= 1'b0;
    cyc(8);
    check(flt.overcurrent_fault, 1'b1);
    @(posedge clk);
    enable_in <= 1'b0;
    cyc(4);
    check(flt.overcurrent_fault, 1'b0);
    por_reset();
  endtask

  // Overvoltage latch, low-side toggling, survives enable low
  task automatic test_ov();
    bring_up();
    @(posedge clk);
    cmp.fb_above_ovr <= 1'b1;
    cyc(VF + 8);
    check(flt.overvoltage_fault, 1'b1);
    check(pg, `BFSUP_PG_65_OHM);
    check(hs_gate, 1'b0);
    check(ls_gate, 1'b1);
    @(posedge clk);
    cmp.fb_above_ovr <= 1'b0;
    cmp.fb_below_ovf <= 1'b1;
    cyc(2);
    check(ls_gate, 1'b1);
    cyc(VF + 6);
    check(ls_gate, 1'b0);
    @(posedge clk);
    cmp.fb_below_ovf <= 1'b0;
    cmp.fb_above_ovr <= 1'b1;
    cyc(VF + 8);
    check(ls_gate, 1'b1);
    @(posedge clk);
    cmp.fb_above_ovr <= 1'b0;
    enable_in        <= 1'b0;
    cyc(6);
    check(flt.overvoltage_fault, 1'b1);
    check(pg, `BFSUP_PG_65_OHM);
    por_reset();
    check(flt.overvoltage_fault, 1'b0);
  endtask

  // Over-temperature suspend, resume, faults still watched
  task automatic test_ot();
    bring_up();
    @(posedge clk);
    cmp.ot_hot   <= 1'b1;
    pwm_high_req <= 1'b0;
    pwm_low_req  <= 1'b1;
    cyc(6);
    check(flt.overtemp_state, 1'b1);
    check({hs_gate, ls_gate}, 2'h0);
    check(pg, `BFSUP_PG_RELEASE);
    check(flt[3:1], 3'h0);
    @(posedge clk);
    cmp.ot_hot <= 1'b0;
    cyc(6);
    check(flt.overtemp_state, 1'b0);
    check(ls_gate, 1'b1);
    @(posedge clk);
    pwm_high_req    <= 1'b1;
    pwm_low_req     <= 1'b0;
    cmp.ot_hot      <= 1'b1;
    cmp.fb_below_uv <= 1'b1;
    cyc(VF + 8);
    check(flt.undervoltage_fault, 1'b1);
    check(flt.overtemp_state, 1'b1);
    // Comparator still hot: only enable low or a supply dip can clear the state
    @(posedge clk);
    enable_in  <= 1'b0;
    cyc(6);
    check(flt.overtemp_state, 1'b0);
    check(flt.undervoltage_fault, 1'b0);
    por_reset();
  endtask

  // ----------------------------------------------------------------
  // Clock, sequence, watchdog and verdict
  // ----------------------------------------------------------------
  // Free-running clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    n_mismatch      = 0;
    samples_checked = 0;
    rst_b           = 1'b0;
    por_ok          = 1'b1;
    enable_in       = 1'b0;
    cmp             = '0;
    pwm_high_req    = 1'b1;
    pwm_low_req     = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    cyc(2);
    check(clamp, 1'b1);
    check(pg, `BFSUP_PG_95_OHM);
    test_por_hold();
    test_uv();
    test_oc();
    test_ov();
    test_ot();
    conclude();
  end

  // Hang guard, far beyond the few hundred cycles needed
  initial begin
    #40000;
    n_mismatch++;
    conclude();
  end
endmodule // test_buck_fault_supervisor
